//--- hw/fmt_pkg.sv
// constants, register map and field layout of the output formatter
// Summary of operation
// - mode field 00 darkens every output
// - single-ended data changes on clock rise
// - single-ended strobe off except I/Q or test pattern
// - ddr: seven data pairs, clock, flag pair
// - I/Q words sequential, strobe with I
// - strobe zero outside I/Q mode, save pattern 111
// - ddr normal: overrange on falling phase
// - ddr I/Q: overrange fall, strobe rise
// - overrange high on either overflow
// - overrange shares raw data latency
// - post-processing delays data, not overrange
// - per-pair polarity inversion bits
// - drive current select, 3.5 mA default
// - bit enables internal termination
// - output rate reduction by divider
// - ddr clock phase shift supported
// - phase enable, three delay fields
// - randomizer xors lsb into others
// - test pattern replaces converter data
// - pattern 111 gives 16-bit lfsr sequence
// - taps 1+x4+x13+x15+x16
// - top 14 bits data, msb flag, next strobe
// - pattern on all single-ended pins
package fmt_pkg;
  localparam logic [7:0] OFS_RATE = 8'h02;
  localparam logic [7:0] OFS_RANDOM = 8'h07;
  localparam logic [7:0] OFS_DLL_DLY = 8'h52;
  localparam logic [7:0] OFS_MODE = 8'h62;
  localparam logic [7:0] OFS_DRIVER = 8'h63;
  localparam logic [7:0] OFS_PHASE_EN = 8'h64;
  localparam logic [7:0] OFS_POL = 8'h65;
  localparam logic [7:0] OFS_FLAG_CTL = 8'h68;
  localparam logic [7:0] OFS_PLL_DLY = 8'h6d;
  localparam logic [7:0] OFS_USER0 = 8'h74;
  localparam logic [7:0] OFS_USER1 = 8'h75;
  localparam logic [7:0] OFS_USER2 = 8'h76;
  localparam logic [7:0] OFS_USER3 = 8'h77;
  // output mode field, bits 1:0 of the mode register
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CMOS = 2'h1;
  // test pattern field, bits 5:3 of the mode register
  localparam int PAT_LSB = 3;
  localparam logic [2:0] PAT_NONE = 3'h0;
  localparam logic [2:0] PAT_ZERO = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_ALT = 3'h3;
  localparam logic [2:0] PAT_USER = 3'h4;
  localparam logic [2:0] PAT_PN = 3'h7;
  localparam logic [13:0] ALT_A = 14'h2aaa;
  localparam logic [13:0] ALT_B = 14'h1555;
  // driver register: bits 2:0 current, bit 3 termination
  localparam int TERM_BIT = 3;
  // phase enable register: bit 0 enable, bits 3:1 decimation delay
  localparam int DEC_DLY_LSB = 1;
  // reset values
  localparam logic [7:0] RST_MODE = 8'h02;
  localparam logic [7:0] RST_DRIVER = 8'h01;
  localparam logic [15:0] PN_SEED = 16'hffff;
  // word carried to the link domain
  localparam int W_FLAG = 14;
  localparam int W_STROBE = 15;
  localparam int W_STROBE_EN = 16;
  localparam int W_WIDTH = 17;
endpackage

//--- hw/fmt_sync.sv
// three-stage synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ps
module fmt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic [WIDTH-1:0] din, // foreign-domain level
  output logic [WIDTH-1:0] dout // filtered level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // stage one is read by stage two only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per bit: hold the old value while stages disagree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          dout[i] <= 1'b0;
        end else if (s2_ff[i] == s3_ff[i]) begin
          dout[i] <= s3_ff[i];
        end
      end
    end
  endgenerate
endmodule

//--- hw/fmt_lfsr.sv
// sixteen-bit pseudo-random generator for the output test pattern
`timescale 1ns/1ps
module fmt_lfsr (
  input wire logic clk, // sample clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic step, // advance one state
  output logic [15:0] value // current state
);
  logic fb;

  // taps at 16, 15, 13 and 4
  assign fb = value[15] ^ value[14] ^ value[12] ^ value[3];

  // seed is nonzero so the sequence never locks up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value <= fmt_pkg::PN_SEED;
    end else if (step) begin
      value <= {value[14:0], fb};
    end
  end
endmodule

//--- hw/adc_digital_output_formatter.sv
// output formatter: register file, word forming, link-domain output stage
`timescale 1ns/1ps
module adc_digital_output_formatter #(
  parameter int DIGITAL_POST_PROCESSING_DELAY = 4
) (
  input wire logic clk_sys, // sample clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic link_clk, // output clock domain
  input wire logic sample_valid, // one-cycle sample strobe
  input wire logic [13:0] sample_data, // converter word
  input wire logic over_pos, // input above full scale
  input wire logic over_neg, // input below full scale
  input wire logic sample_is_i, // word is in-phase
  input wire logic iq_active, // I/Q output mode on
  input wire logic digital_post_processing_enable, // post-processing adds data delay
  input wire logic decim_used, // decimation active
  input wire logic pll_used, // pll timing source
  input wire logic reg_we, // register write strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle late
  output logic [13:0] cmos_data, // single-ended data
  output logic cmos_flag, // single-ended overrange_flag
  output logic cmos_strobe, // single-ended word_strobe
  output logic cmos_data_oe, // data and flag drive enable
  output logic cmos_strobe_oe, // strobe drive enable
  output logic [6:0] ddr_rise, // pair values while clock high
  output logic [6:0] ddr_fall, // pair values while clock low
  output logic ddr_flag_rise, // flag pair while clock high
  output logic ddr_flag_fall, // flag pair while clock low
  output logic ddr_oe, // differential drive enable
  output logic data_clock_en, // gate for data_clock_out
  output logic [2:0] clock_phase_delay, // selected phase step
  output logic [2:0] driver_current_select, // driver current code
  output logic termination_en // internal termination on
);
  logic [7:0] rate_ff, random_ff, dll_ff, mode_ff, driver_ff, phase_en_ff;
  logic [7:0] pol_ff, flag_ctl_ff, pll_ff, user0_ff, user1_ff, user2_ff, user3_ff;
  logic [3:0] rate_cnt_ff;
  logic [13:0] dl_ff [DIGITAL_POST_PROCESSING_DELAY];
  // width of the word handed to the link domain
  localparam int W_WIDTH_L = fmt_pkg::W_WIDTH;
  logic [W_WIDTH_L-1:0] word_ff, nxt_word;
  logic toggle_ff, alt_ff, accept, ovr_now;
  logic [13:0] data_sel, pat_data;
  logic [2:0] pattern;
  logic [15:0] pn;

  assign pattern = mode_ff[fmt_pkg::PAT_LSB +: 3];

  // register file, quasi-static toward the link domain
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rate_ff <= 8'h00;
      random_ff <= 8'h00;
      dll_ff <= 8'h00;
      mode_ff <= fmt_pkg::RST_MODE;
      driver_ff <= fmt_pkg::RST_DRIVER;
      phase_en_ff <= 8'h00;
      pol_ff <= 8'h00;
      flag_ctl_ff <= 8'h00;
      pll_ff <= 8'h00;
      user0_ff <= 8'h00;
      user1_ff <= 8'h00;
      user2_ff <= 8'h00;
      user3_ff <= 8'h00;
    end else if (reg_we) begin
      if (reg_addr == fmt_pkg::OFS_RATE) begin
        rate_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_RANDOM) begin
        random_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_DLL_DLY) begin
        dll_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_MODE) begin
        mode_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_DRIVER) begin
        driver_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_PHASE_EN) begin
        phase_en_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_POL) begin
        pol_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_FLAG_CTL) begin
        flag_ctl_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_PLL_DLY) begin
        pll_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_USER0) begin
        user0_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_USER1) begin
        user1_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_USER2) begin
        user2_ff <= reg_wdata;
      end else if (reg_addr == fmt_pkg::OFS_USER3) begin
        user3_ff <= reg_wdata;
      end
    end
  end

  // read-back; unmapped offsets read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == fmt_pkg::OFS_RATE) begin
      reg_rdata <= rate_ff;
    end else if (reg_addr == fmt_pkg::OFS_RANDOM) begin
      reg_rdata <= random_ff;
    end else if (reg_addr == fmt_pkg::OFS_DLL_DLY) begin
      reg_rdata <= dll_ff;
    end else if (reg_addr == fmt_pkg::OFS_MODE) begin
      reg_rdata <= mode_ff;
    end else if (reg_addr == fmt_pkg::OFS_DRIVER) begin
      reg_rdata <= driver_ff;
    end else if (reg_addr == fmt_pkg::OFS_PHASE_EN) begin
      reg_rdata <= phase_en_ff;
    end else if (reg_addr == fmt_pkg::OFS_POL) begin
      reg_rdata <= pol_ff;
    end else if (reg_addr == fmt_pkg::OFS_FLAG_CTL) begin
      reg_rdata <= flag_ctl_ff;
    end else if (reg_addr == fmt_pkg::OFS_PLL_DLY) begin
      reg_rdata <= pll_ff;
    end else if (reg_addr == fmt_pkg::OFS_USER0) begin
      reg_rdata <= user0_ff;
    end else if (reg_addr == fmt_pkg::OFS_USER1) begin
      reg_rdata <= user1_ff;
    end else if (reg_addr == fmt_pkg::OFS_USER2) begin
      reg_rdata <= user2_ff;
    end else if (reg_addr == fmt_pkg::OFS_USER3) begin
      reg_rdata <= user3_ff;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // driver settings and clock phase step
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      driver_current_select <= 3'h0;
      termination_en <= 1'b0;
      clock_phase_delay <= 3'h0;
    end else begin
      driver_current_select <= driver_ff[2:0];
      termination_en <= driver_ff[fmt_pkg::TERM_BIT];
      if (pll_used) begin
        clock_phase_delay <= pll_ff[2:0];
      end else if (!phase_en_ff[0]) begin
        clock_phase_delay <= 3'h0;
      end else if (decim_used) begin
        clock_phase_delay <= phase_en_ff[fmt_pkg::DEC_DLY_LSB +: 3];
      end else begin
        clock_phase_delay <= dll_ff[2:0];
      end
    end
  end

  // rate divider keeps one sample in rate[3:0]+1
  assign accept = sample_valid && (rate_cnt_ff == 4'h0);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rate_cnt_ff <= 4'h0;
    end else if (sample_valid) begin
      rate_cnt_ff <= (rate_cnt_ff == 4'h0) ? rate_ff[3:0] : rate_cnt_ff - 4'h1;
    end
  end

  // extra data delay under post-processing; the flag skips it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DIGITAL_POST_PROCESSING_DELAY; i++) begin
        dl_ff[i] <= 14'h0000;
      end
    end else if (sample_valid) begin
      dl_ff[0] <= sample_data;
      for (int i = 1; i < DIGITAL_POST_PROCESSING_DELAY; i++) begin
        dl_ff[i] <= dl_ff[i-1];
      end
    end
  end
  assign data_sel = digital_post_processing_enable ? dl_ff[DIGITAL_POST_PROCESSING_DELAY-1] : sample_data;
  assign ovr_now = over_pos | over_neg;

  fmt_lfsr u_lfsr (
    .clk(clk_sys),
    .reset(reset),
    .step(accept && (pattern == fmt_pkg::PAT_PN)),
    .value(pn)
  );

  // alternating, user and unused pattern codes switch between two words
  always_comb begin
    pat_data = 14'h0000;
    case (pattern)
      fmt_pkg::PAT_ZERO: pat_data = 14'h0000;
      fmt_pkg::PAT_ONES: pat_data = 14'h3fff;
      fmt_pkg::PAT_ALT: pat_data = alt_ff ? fmt_pkg::ALT_B : fmt_pkg::ALT_A;
      fmt_pkg::PAT_USER: pat_data = alt_ff ? {user3_ff[5:0], user2_ff} : {user1_ff[5:0], user0_ff};
      fmt_pkg::PAT_PN: pat_data = pn[15:2];
      default: pat_data = alt_ff ? 14'h3fff : 14'h0000;
    endcase
  end

  // word forming: pattern replaces data, randomizer on live data only
  always_comb begin
    nxt_word = '0;
    if (pattern != fmt_pkg::PAT_NONE) begin
      nxt_word[13:0] = pat_data;
      nxt_word[fmt_pkg::W_FLAG] = (pattern == fmt_pkg::PAT_PN) && pn[15];
      nxt_word[fmt_pkg::W_STROBE] = (pattern == fmt_pkg::PAT_PN) && pn[14];
      nxt_word[fmt_pkg::W_STROBE_EN] = 1'b1;
    end else begin
      nxt_word[13:0] = data_sel;
      if (random_ff[0]) begin
        nxt_word[13:1] = data_sel[13:1] ^ {13{data_sel[0]}};
      end
      nxt_word[fmt_pkg::W_FLAG] = ovr_now;
      nxt_word[fmt_pkg::W_STROBE] = iq_active && sample_is_i;
      nxt_word[fmt_pkg::W_STROBE_EN] = iq_active;
    end
  end

  // word held steady across the crossing; toggle marks a new one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      word_ff <= '0;
      toggle_ff <= 1'b0;
      alt_ff <= 1'b0;
    end else if (accept) begin
      word_ff <= nxt_word;
      toggle_ff <= ~toggle_ff;
      alt_ff <= ~alt_ff;
    end
  end

  // ---- link domain ----
  logic [10:0] synced;
  logic seen_ff;
  logic [W_WIDTH_L-1:0] cap_ff;
  logic [1:0] mode_l;
  logic [6:0] pol_l;
  logic fpol_l;

  fmt_sync #(.WIDTH(11)) u_sync (
    .clk(link_clk),
    .reset(reset),
    .din({flag_ctl_ff[0], pol_ff[6:0], mode_ff[1:0], toggle_ff}),
    .dout(synced)
  );
  assign mode_l = synced[2:1];
  assign pol_l = synced[9:3];
  assign fpol_l = synced[10];

  // capture once per toggle change
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      seen_ff <= 1'b0;
      cap_ff <= '0;
    end else if (synced[0] != seen_ff) begin
      seen_ff <= synced[0];
      cap_ff <= word_ff;
    end
  end

  // single-ended pins update on the rising link edge
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      cmos_data <= 14'h0000;
      cmos_flag <= 1'b0;
      cmos_strobe <= 1'b0;
      cmos_data_oe <= 1'b0;
      cmos_strobe_oe <= 1'b0;
    end else begin
      cmos_data <= cap_ff[13:0];
      cmos_flag <= cap_ff[fmt_pkg::W_FLAG];
      cmos_strobe <= cap_ff[fmt_pkg::W_STROBE];
      cmos_data_oe <= (mode_l == fmt_pkg::MODE_CMOS);
      cmos_strobe_oe <= (mode_l == fmt_pkg::MODE_CMOS) && cap_ff[fmt_pkg::W_STROBE_EN];
    end
  end

  // differential pairs: two bits each, polarity on both phases
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ddr_rise <= 7'h00;
      ddr_fall <= 7'h00;
      ddr_flag_rise <= 1'b0;
      ddr_flag_fall <= 1'b0;
      ddr_oe <= 1'b0;
      data_clock_en <= 1'b0;
    end else begin
      for (int k = 0; k < 7; k++) begin
        ddr_rise[k] <= cap_ff[2*k+1] ^ pol_l[k];
        ddr_fall[k] <= cap_ff[2*k] ^ pol_l[k];
      end
      ddr_flag_rise <= cap_ff[fmt_pkg::W_STROBE] ^ fpol_l;
      ddr_flag_fall <= cap_ff[fmt_pkg::W_FLAG] ^ fpol_l;
      ddr_oe <= (mode_l != fmt_pkg::MODE_OFF) && (mode_l != fmt_pkg::MODE_CMOS);
      data_clock_en <= (mode_l != fmt_pkg::MODE_OFF);
    end
  end

  // ---- checks ----
  sequence s_plain_accept;
    accept && (pattern == fmt_pkg::PAT_NONE);
  endsequence

  // live data under post-processing, randomizer off
  sequence s_delayed_accept;
    s_plain_accept ##0 digital_post_processing_enable ##0 !random_ff[0];
  endsequence

  // divider reloads on every kept sample, so the next rate[3:0] samples are skipped
  a_rate_skip: assert property (@(posedge clk_sys) disable iff (reset)
    accept |=> (rate_cnt_ff == $past(rate_ff[3:0]))) else $error("divider not reloaded after sample");
  a_flag_aligned: assert property (@(posedge clk_sys) disable iff (reset)
    s_plain_accept |=> (word_ff[fmt_pkg::W_FLAG] == ($past(over_pos) | $past(over_neg))))
    else $error("overrange not aligned with word");
  a_strobe_off: assert property (@(posedge clk_sys) disable iff (reset)
    s_plain_accept ##0 !iq_active |=> !word_ff[fmt_pkg::W_STROBE] && !word_ff[fmt_pkg::W_STROBE_EN])
    else $error("strobe set outside I/Q mode");
  a_random_lsb: assert property (@(posedge clk_sys) disable iff (reset)
    s_plain_accept ##0 random_ff[0] ##0 !digital_post_processing_enable |=>
      (word_ff[13:0] ^ {{13{word_ff[0]}}, 1'b0}) == $past(sample_data))
    else $error("randomized word does not decode");
  a_pattern_only: assert property (@(posedge clk_sys) disable iff (reset)
    accept && (pattern == fmt_pkg::PAT_ONES) |=> (word_ff[13:0] == 14'h3fff) && !word_ff[fmt_pkg::W_FLAG])
    else $error("converter data leaked into pattern");
  a_pn_map: assert property (@(posedge clk_sys) disable iff (reset)
    accept && (pattern == fmt_pkg::PAT_PN) |=>
      (word_ff[15:0] == {$past(pn[14]), $past(pn[15]), $past(pn[15:2])}))
    else $error("pseudo-random bits misplaced");
  a_pn_step: assert property (@(posedge clk_sys) disable iff (reset)
    accept && (pattern == fmt_pkg::PAT_PN) |=> (pn[0] == ^($past(pn) & 16'hd008)))
    else $error("generator feedback wrong");
  a_phase_gate: assert property (@(posedge clk_sys) disable iff (reset)
    !pll_used && !phase_en_ff[0] ##1 !pll_used |-> (clock_phase_delay == 3'h0))
    else $error("phase delay without enable");
  a_off_dark: assert property (@(posedge link_clk) disable iff (reset)
    (mode_l == fmt_pkg::MODE_OFF) [*2] |-> !cmos_data_oe && !cmos_strobe_oe && !ddr_oe && !data_clock_en)
    else $error("outputs driven while disabled");
  a_ddr_flag: assert property (@(posedge link_clk) disable iff (reset)
    $stable(cap_ff) && $stable(fpol_l) |=> (ddr_flag_fall == ($past(cap_ff[fmt_pkg::W_FLAG]) ^ $past(fpol_l))))
    else $error("flag not on falling phase");
  a_strobe_oe_off: assert property (@(posedge link_clk) disable iff (reset)
    (mode_l != fmt_pkg::MODE_CMOS) |=> !cmos_strobe_oe) else $error("strobe driven outside single-ended mode");

  // sample-domain checks on strobe, delayed data and user words
  a_strobe_iq: assert property (@(posedge clk_sys) disable iff (reset)
    s_plain_accept ##0 iq_active |=> (word_ff[fmt_pkg::W_STROBE] == $past(sample_is_i)))
    else $error("strobe not with in-phase word");
  a_flag_early: assert property (@(posedge clk_sys) disable iff (reset)
    s_delayed_accept |=> (word_ff[13:0] == $past(dl_ff[DIGITAL_POST_PROCESSING_DELAY-1]))
      && (word_ff[fmt_pkg::W_FLAG] == ($past(over_pos) | $past(over_neg))))
    else $error("overrange not leading delayed data");
  a_user_word: assert property (@(posedge clk_sys) disable iff (reset)
    accept && (pattern == fmt_pkg::PAT_USER) |=> (word_ff[7:0] == ($past(alt_ff) ? $past(user2_ff) : $past(user0_ff))))
    else $error("user pattern word wrong");
endmodule

//--- sim/host_capture.sv
// host-side model: latches single-ended data on the falling clock edge and undoes the randomizer
`timescale 1ns/1ps
module host_capture (
  input wire logic link_clk, // forwarded output clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic data_clock_en, // clock leaves the device only when high
  input wire logic [13:0] cmos_data, // single-ended data pins
  input wire logic cmos_data_oe, // pins driven by the device
  input wire logic rand_on, // host knows the randomizer is on
  output logic [13:0] word_got // decoded sample
);
  logic [13:0] line_v;
  logic [13:0] last_ff;
  // undriven pins float: show the inverse of the last value so a stale word never matches
  assign line_v = cmos_data_oe ? cmos_data : ~last_ff;
  // capture half a period after launch; a gated clock means no edge at all
  always_ff @(negedge link_clk or posedge reset) begin
    if (reset) begin
      last_ff <= 14'h0000;
      word_got <= 14'h0000;
    end else if (data_clock_en) begin
      last_ff <= line_v;
      word_got <= rand_on ? (line_v ^ {{13{line_v[0]}}, 1'b0}) : line_v;
    end
  end
endmodule

//--- sim/adc_digital_output_formatter_tb.sv
// self-checking bench of the output formatter with a host capture model
`timescale 1ns/1ps
module adc_digital_output_formatter_tb;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic sample_valid = 1'b0;
  logic [13:0] sample_data = 14'h0000;
  logic over_pos = 1'b0;
  logic over_neg = 1'b0;
  logic sample_is_i = 1'b0;
  logic iq_active = 1'b0;
  logic decim_used = 1'b0;
  logic pll_used = 1'b0;
  logic reg_we = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic digital_post_processing_enable = 1'b0;
  logic rand_on = 1'b0;
  logic [7:0] reg_rdata;
  logic [13:0] cmos_data;
  logic cmos_flag, cmos_strobe, cmos_data_oe, cmos_strobe_oe;
  logic [6:0] ddr_rise, ddr_fall;
  logic ddr_flag_rise, ddr_flag_fall, ddr_oe, data_clock_en, termination_en;
  logic [2:0] clock_phase_delay, driver_current_select;
  logic [13:0] word_got;
  int err_total = 0;
  int compares = 0;
  adc_digital_output_formatter #(.DIGITAL_POST_PROCESSING_DELAY(4)) adc_digital_output_formatter_i (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk), .sample_valid(sample_valid),
    .sample_data(sample_data), .over_pos(over_pos), .over_neg(over_neg), .sample_is_i(sample_is_i),
    .iq_active(iq_active), .digital_post_processing_enable(digital_post_processing_enable), .decim_used(decim_used), .pll_used(pll_used),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmos_data(cmos_data), .cmos_flag(cmos_flag), .cmos_strobe(cmos_strobe), .cmos_data_oe(cmos_data_oe),
    .cmos_strobe_oe(cmos_strobe_oe), .ddr_rise(ddr_rise), .ddr_fall(ddr_fall), .ddr_flag_rise(ddr_flag_rise),
    .ddr_flag_fall(ddr_flag_fall), .ddr_oe(ddr_oe), .data_clock_en(data_clock_en),
    .clock_phase_delay(clock_phase_delay), .driver_current_select(driver_current_select),
    .termination_en(termination_en));
  host_capture host_capture_i (.link_clk(link_clk), .reset(reset), .data_clock_en(data_clock_en),
    .cmos_data(cmos_data), .cmos_data_oe(cmos_data_oe), .rand_on(rand_on), .word_got(word_got));
  // sample clock, and a link clock whose edges stay clear of the reset release
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  task give_verdict;
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk_w(input logic [13:0] g, input logic [13:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t word got %h exp %h", $time, g, e);
    end
  endtask
  task chk_r(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task chk_b(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  // config crosses to the link domain through a synchroniser: give it time
  task settle;
    repeat (6) @(posedge link_clk);
    #1;
  endtask
  // one sample strobe, accepted or not by the divider, then wait until it has passed the link output stage
  task send(input logic [13:0] d, input logic op, input logic on, input logic isi);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_data <= d;
    over_pos <= op;
    over_neg <= on;
    sample_is_i <= isi;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    repeat (12) @(posedge link_clk);
    #1;
  endtask
  task t_reset;
    logic [7:0] v;
    reg_rd(8'h62, v);
    chk_r(v, 8'h02);
    reg_rd(8'h63, v);
    chk_r(v, 8'h01);
    chk_r({5'h00, driver_current_select}, 8'h01);
    reg_rd(8'h07, v);
    chk_r(v, 8'h00);
    reg_rd(8'h10, v);
    chk_r(v, 8'h00);
  endtask
  task t_off;
    reg_wr(8'h62, 8'h00);
    settle;
    chk_b(data_clock_en, 1'b0);
    chk_b(cmos_data_oe | ddr_oe | cmos_strobe_oe, 1'b0);
  endtask
  task t_cmos;
    reg_wr(8'h62, 8'h01);
    settle;
    send(14'h1a5c, 1'b0, 1'b1, 1'b0);
    chk_w(cmos_data, 14'h1a5c);
    chk_w(word_got, 14'h1a5c);
    chk_b(cmos_flag, 1'b1);
    chk_b(cmos_strobe_oe, 1'b0);
    chk_b(cmos_strobe, 1'b0);
    send(14'h0001, 1'b1, 1'b0, 1'b0);
    chk_b(cmos_flag, 1'b1);
    send(14'h0002, 1'b0, 1'b0, 1'b0);
    chk_b(cmos_flag, 1'b0);
  endtask
  // keep one sample in two: the second word never reaches the pins
  task t_rate;
    reg_wr(8'h02, 8'h01);
    send(14'h0155, 1'b0, 1'b0, 1'b0);
    chk_w(cmos_data, 14'h0155);
    send(14'h0266, 1'b0, 1'b0, 1'b0);
    chk_w(cmos_data, 14'h0155);
    reg_wr(8'h02, 8'h00);
  endtask
  // data lags four samples, the flag does not
  task t_digital_post_processing;
    @(posedge clk_sys);
    digital_post_processing_enable <= 1'b1;
    send(14'h0aaa, 1'b1, 1'b0, 1'b0);
    chk_b(cmos_flag, 1'b1);
    for (int n = 1; n < 5; n++) send(14'h0aaa + 14'(n), 1'b0, 1'b0, 1'b0);
    chk_w(cmos_data, 14'h0aaa);
    chk_b(cmos_flag, 1'b0);
    @(posedge clk_sys);
    digital_post_processing_enable <= 1'b0;
  endtask
  task t_random;
    reg_wr(8'h07, 8'h01);
    rand_on = 1'b1;
    send(14'h2461, 1'b1, 1'b0, 1'b0);
    chk_w(cmos_data, 14'h2461 ^ 14'h3ffe);
    chk_b(cmos_flag, 1'b1);
    chk_w(word_got, 14'h2461);
    reg_wr(8'h07, 8'h00);
    rand_on = 1'b0;
  endtask
  task t_ddr;
    logic [13:0] s;
    logic [6:0] p;
    logic [6:0] er, ef;
    s = 14'h2c35;
    p = 7'h55;
    for (int k = 0; k < 7; k++) begin
      er[k] = s[2*k+1] ^ p[k];
      ef[k] = s[2*k] ^ p[k];
    end
    reg_wr(8'h62, 8'h02);
    reg_wr(8'h65, 8'h55);
    reg_wr(8'h68, 8'h01);
    settle;
    send(s, 1'b0, 1'b1, 1'b0);
    chk_b(ddr_oe & data_clock_en & ~cmos_data_oe, 1'b1);
    chk_r({1'b0, ddr_rise}, {1'b0, er});
    chk_r({1'b0, ddr_fall}, {1'b0, ef});
    chk_b(ddr_flag_fall, 1'b0);
    chk_b(ddr_flag_rise, 1'b1);
  endtask
  task t_iq;
    @(posedge clk_sys);
    iq_active <= 1'b1;
    send(14'h0100, 1'b0, 1'b0, 1'b1);
    chk_b(ddr_flag_rise, 1'b0);
    chk_b(ddr_flag_fall, 1'b1);
    send(14'h0200, 1'b1, 1'b0, 1'b0);
    chk_b(ddr_flag_rise, 1'b1);
    chk_b(ddr_flag_fall, 1'b0);
    @(posedge clk_sys);
    iq_active <= 1'b0;
    reg_wr(8'h68, 8'h00);
  endtask
  task t_pattern;
    reg_wr(8'h62, 8'h11);
    settle;
    send(14'h0123, 1'b1, 1'b0, 1'b0);
    chk_w(cmos_data, 14'h3fff);
    chk_b(cmos_flag, 1'b0);
    chk_b(cmos_strobe_oe, 1'b1);
  endtask
  // fourteen accepts so far, so word A comes first
  task t_user;
    logic [13:0] v1;
    reg_wr(8'h74, 8'h3c);
    reg_wr(8'h75, 8'h12);
    reg_wr(8'h76, 8'hc3);
    reg_wr(8'h77, 8'h2d);
    reg_wr(8'h62, 8'h21);
    send(14'h0000, 1'b1, 1'b0, 1'b0);
    v1 = cmos_data;
    chk_b(cmos_flag, 1'b0);
    send(14'h0000, 1'b1, 1'b0, 1'b0);
    chk_w(v1, 14'h123c);
    chk_w(cmos_data, 14'h2dc3);
  endtask
  task t_pn;
    logic [13:0] v1;
    reg_wr(8'h62, 8'h39);
    send(14'h0000, 1'b0, 1'b0, 1'b0);
    v1 = cmos_data;
    chk_b(cmos_flag, cmos_data[13]);
    chk_b(cmos_strobe, cmos_data[12]);
    send(14'h0000, 1'b0, 1'b0, 1'b0);
    chk_w({1'b0, cmos_data[13:1]}, {1'b0, v1[12:0]});
    chk_b(cmos_flag, cmos_data[13]);
  endtask
  task t_ctrl;
    logic [7:0] v;
    reg_wr(8'h63, 8'h0b);
    reg_wr(8'h64, 8'h0b);
    reg_wr(8'h52, 8'h03);
    reg_wr(8'h6d, 8'h06);
    decim_used <= 1'b1;
    reg_rd(8'h63, v);
    chk_r(v, 8'h0b);
    chk_r({5'h00, driver_current_select}, 8'h03);
    chk_b(termination_en, 1'b1);
    chk_r({5'h00, clock_phase_delay}, 8'h05);
    decim_used <= 1'b0;
    reg_rd(8'h52, v);
    chk_r({5'h00, clock_phase_delay}, 8'h03);
    pll_used <= 1'b1;
    reg_rd(8'h6d, v);
    chk_r({5'h00, clock_phase_delay}, 8'h06);
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    #400000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_off;
    t_cmos;
    t_rate;
    t_digital_post_processing;
    t_random;
    t_ddr;
    t_iq;
    t_pattern;
    t_user;
    t_pn;
    t_ctrl;
    give_verdict;
  end
endmodule
